// ### hw/apcrc_pkg.sv
package apcrc_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // timing
    localparam int CLK_MHZ = 125;
    localparam int STRAP_SETTLE_CYCLES = 4;
    // internal oscillator start-up routine length
    localparam int STARTUP_NS = 2000;
    localparam int STARTUP_CYCLES = (STARTUP_NS * CLK_MHZ + 999) / 1000;
    // longest time to full operation after sleep, a whole number of clk cycles
    localparam int WAKE_US = 100;
    localparam int WAKE_CYCLES_DEF = WAKE_US * CLK_MHZ;
    // power-up time after full power-down
    localparam int PUP_MS = 10;
    localparam int PUP_CYCLES_DEF = PUP_MS * 1000 * CLK_MHZ;
    // modulator clock half period in high performance mode, in clk cycles
    localparam int MOD_HALF_HP = 1;

    localparam int NUM_CH = 4;

    ////////////////////////////////////////////////////////////////////////////////
    // register map (byte addresses)
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_CHPD = 4'h4;
    localparam logic [3:0] ADDR_STATUS = 4'h8;

    localparam int CTRL_CORR_BIT = 0;
    localparam int CTRL_XCLK_BIT = 1;
    localparam int CTRL_LOWPWR_BIT = 2;
    localparam int CTRL_SLEEP_BIT = 3;
    localparam int CTRL_SRST_BIT = 4;

    localparam int ST_SERIAL_BIT = 0;
    localparam int ST_CRYSTAL_BIT = 1;
    localparam int ST_EXTCLK_BIT = 2;
    localparam int ST_SLEEP_BIT = 3;
    localparam int ST_READY_BIT = 4;

    localparam logic CORR_RST = 1'h0;
    localparam logic XCLK_RST = 1'h0;
    localparam logic LOWPWR_RST = 1'h0;
    localparam logic SLEEP_RST = 1'h0;
    localparam logic [NUM_CH-1:0] CHPD_RST = 4'h0;

    ////////////////////////////////////////////////////////////////////////////////
    // types
    typedef enum logic [2:0] {
        PH_STRAP, PH_STARTUP, PH_RUN, PH_SLEEP, PH_WAKE, PH_PDOWN, PH_PUP
    } apcrc_phase_t;

    typedef struct packed {
        logic [3:0] adr;
        logic [31:0] dat;
        logic [3:0] sel;
        logic we;
        logic cyc;
        logic stb;
    } apcrc_wb_req_t;

    typedef struct packed {
        logic controlSelect;
        logic clockSourceStrap;
        logic fullPowerDownPinN;
        logic resetPinN;
        logic lowPowerPin;
    } apcrc_pins_t;

    localparam apcrc_pins_t PINS_IDLE = 5'h06;

    typedef struct packed {
        logic [NUM_CH-1:0] channelOn;
        logic [NUM_CH-1:0] channelInputHiZ;
        logic referenceInputHiZ;
        logic analogOn;
        logic regulatorOn;
    } apcrc_power_t;

    localparam apcrc_power_t POWER_OFF = 11'h07D;

    typedef struct packed {
        logic useExternalClock;
        logic crystalClockOutEnable;
        logic lowPowerMode;
    } apcrc_clock_t;

    typedef struct packed {
        logic enable;
        logic [2:0] currentQuarters;
    } apcrc_refcorr_t;

    // reference current in quarters: one quarter per running channel
    function automatic logic [2:0] apcrc_quarters(input logic [NUM_CH-1:0] on);
        logic [2:0] q;
        q = 3'h0;
        for (int i = 0; i < NUM_CH; i++) begin
            q = q + {2'h0, on[i]};
        end
        return q;
    endfunction

endpackage

// ### hw/apcrc_mod_clock.sv
module apcrc_mod_clock
    import apcrc_pkg::*;
#(
    parameter int HALF_HP = MOD_HALF_HP
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // control
    input wire logic run,
    input wire logic halfRate,
    // modulator clock
    output logic modClk
);

    if (HALF_HP < 1 || 2 * HALF_HP > 255) begin : gBadHalf
        $error("HALF_HP out of range");
    end

    typedef struct packed {
        logic [7:0] cnt;
        logic modClk;
    } apcrc_modclk_state_t;

    apcrc_modclk_state_t r_reg, r_next;
    logic [7:0] limit;

    always_comb begin
        r_next = r_reg;
        // low power doubles the half period, halving the rate
        limit = halfRate ? 8'(2 * HALF_HP - 1) : 8'(HALF_HP - 1); // RL9
        if (!run) begin
            r_next.cnt = 8'h00;
            r_next.modClk = 1'b0;
        end else if (r_reg.cnt >= limit) begin
            r_next.cnt = 8'h00;
            r_next.modClk = ~r_reg.modClk;
        end else begin
            r_next.cnt = r_reg.cnt + 8'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign modClk = r_reg.modClk;

    AST_LOW_POWER_RATE: assert property (@(posedge clk) disable iff (reset) // RL9
        run && $past(run) && halfRate && $past(halfRate) && $changed(r_reg.modClk)
        |-> $past(r_reg.cnt) == 8'(2 * HALF_HP - 1))
        else $error("low power modulator clock not at half rate");

endmodule

// ### hw/apcrc_top.sv
// Operation
// RL1 - pin or serial control chosen once at power-up from the select pin.
// RL2 - serial mode: correction enable bit set compensates reference resistor drop.
// RL3 - correction counts one quarter less reference current per disabled channel.
// RL4 - reference drop correction always off in pin control mode.
// RL5 - start-up runs on internal oscillator, then hands over to external clock.
// RL6 - crystal or CMOS clock strap latched at power-on.
// RL7 - pin mode: crystal clock output follows the crystal strap.
// RL8 - serial mode: crystal clock output off after reset until enabled.
// RL9 - low power mode runs modulators at half the high performance rate.
// RL10 - serial mode: each channel has its own power-down bit.
// RL11 - powered-down channel input is high impedance.
// RL12 - serial mode: setting sleep bit enters sleep.
// RL13 - sleep powers down all but the regulator, registers kept.
// RL14 - full operation within 100 us after leaving sleep.
// RL15 - sleep makes reference and channel inputs high impedance.
// RL16 - power-down pin low powers down all blocks while low.
// RL17 - leaving power-down restores register defaults, 10 ms power-up.
// RL18 - any reset restores defaults and restarts the internal logic.
// RL19 - reset by pin low or self-clearing software reset bit.
// RL20 - clearing sleep bit leaves sleep and starts wake-up.
//
// The Wishbone interface to the registers and the placing of the registers were chosen for this implementation.
module apcrc_top
    import apcrc_pkg::*;
#(
    parameter int WAKE_CYCLES = WAKE_CYCLES_DEF,
    parameter int PUP_CYCLES = PUP_CYCLES_DEF,
    parameter int CNT_W = 21
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // register bus
    input wire apcrc_wb_req_t wbReq,
    output logic wbAck,
    output logic [31:0] wbDatOut,
    // device pins
    input wire apcrc_pins_t pinsIn,
    // power, clock and reference controls
    output apcrc_power_t powerOut,
    output apcrc_clock_t clockOut,
    output apcrc_refcorr_t refCorrOut,
    output logic deviceReady,
    output logic modulatorClock
);

    if (WAKE_CYCLES < 1 || PUP_CYCLES < 1 || STARTUP_CYCLES < 1
        || WAKE_CYCLES >= 2 ** CNT_W || PUP_CYCLES >= 2 ** CNT_W
        || STARTUP_CYCLES >= 2 ** CNT_W) begin : gBadCounts
        $error("counts do not fit CNT_W");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        apcrc_pins_t s1;
        apcrc_pins_t s2;
        apcrc_pins_t s3;
        apcrc_pins_t lvl;
        logic strapDone;
        logic serialMode;
        logic crystalStrap;
        apcrc_phase_t phase;
        logic [CNT_W-1:0] cnt;
        logic corrEn;
        logic xclkEn;
        logic lowPwr;
        logic sleepEn;
        logic softRst;
        logic [NUM_CH-1:0] chPd;
        logic ack;
        logic [31:0] rdat;
        apcrc_power_t power;
        apcrc_clock_t clock;
        apcrc_refcorr_t refCorr;
        logic ready;
    } apcrc_state_t;

    apcrc_state_t r_reg, r_next;

    function automatic apcrc_state_t apcrc_defaults(input apcrc_state_t s);
        apcrc_state_t d;
        d = s;
        d.corrEn = CORR_RST;
        d.xclkEn = XCLK_RST;
        d.lowPwr = LOWPWR_RST;
        d.sleepEn = SLEEP_RST;
        d.chPd = CHPD_RST;
        d.softRst = 1'b0;
        return d;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        logic wr;
        logic live;
        logic analogOn;
        logic [NUM_CH-1:0] on;
        wr = 1'b0;
        live = 1'b0;
        analogOn = 1'b0;
        on = '0;
        r_next = r_reg;

        // pin synchronisers: a level counts once stages two and three agree
        r_next.s1 = pinsIn;
        r_next.s2 = r_reg.s1;
        r_next.s3 = r_reg.s2;
        r_next.lvl = apcrc_pins_t'((r_reg.s3 & ~(r_reg.s2 ^ r_reg.s3))
            | (r_reg.lvl & (r_reg.s2 ^ r_reg.s3)));
        r_next.cnt = r_reg.cnt + {{(CNT_W - 1){1'b0}}, 1'b1};
        r_next.softRst = 1'b0;

        // bus slave: one wait state, unmapped reads return zero
        live = r_reg.phase inside {PH_STARTUP, PH_RUN, PH_SLEEP, PH_WAKE};
        r_next.ack = wbReq.cyc & wbReq.stb & ~r_reg.ack;
        r_next.rdat = '0;
        // pin mode ignores register writes; they are still acknowledged
        wr = r_next.ack & wbReq.we & wbReq.sel[0] & r_reg.serialMode & live;
        if (r_next.ack && !wbReq.we) begin
            case (wbReq.adr)
                ADDR_CTRL: begin
                    r_next.rdat[CTRL_CORR_BIT] = r_reg.corrEn;
                    r_next.rdat[CTRL_XCLK_BIT] = r_reg.xclkEn;
                    r_next.rdat[CTRL_LOWPWR_BIT] = r_reg.lowPwr;
                    r_next.rdat[CTRL_SLEEP_BIT] = r_reg.sleepEn;
                end
                ADDR_CHPD: begin
                    r_next.rdat[NUM_CH-1:0] = r_reg.chPd;
                end
                ADDR_STATUS: begin
                    r_next.rdat[ST_SERIAL_BIT] = r_reg.serialMode;
                    r_next.rdat[ST_CRYSTAL_BIT] = r_reg.crystalStrap;
                    r_next.rdat[ST_EXTCLK_BIT] = r_reg.clock.useExternalClock;
                    r_next.rdat[ST_SLEEP_BIT] = r_reg.phase == PH_SLEEP;
                    r_next.rdat[ST_READY_BIT] = r_reg.ready;
                end
                default: begin
                    r_next.rdat = '0;
                end
            endcase
        end
        if (wr) begin
            case (wbReq.adr)
                ADDR_CTRL: begin
                    r_next.corrEn = wbReq.dat[CTRL_CORR_BIT]; // RL2
                    r_next.xclkEn = wbReq.dat[CTRL_XCLK_BIT]; // RL8
                    r_next.lowPwr = wbReq.dat[CTRL_LOWPWR_BIT];
                    r_next.sleepEn = wbReq.dat[CTRL_SLEEP_BIT]; // RL12
                    r_next.softRst = wbReq.dat[CTRL_SRST_BIT]; // RL19
                end
                ADDR_CHPD: begin
                    r_next.chPd = wbReq.dat[NUM_CH-1:0]; // RL10
                end
                default: begin
                end
            endcase
        end

        // power and clock sequence
        case (r_reg.phase)
            PH_STRAP: begin
                if (r_reg.cnt == CNT_W'(STRAP_SETTLE_CYCLES)) begin
                    r_next.serialMode = r_reg.lvl.controlSelect; // RL1
                    r_next.crystalStrap = r_reg.lvl.clockSourceStrap; // RL6
                    r_next.strapDone = 1'b1;
                    r_next.phase = PH_STARTUP;
                    r_next.cnt = '0;
                end
            end
            PH_STARTUP: begin
                // internal oscillator until the routine ends
                if (r_reg.cnt == CNT_W'(STARTUP_CYCLES - 1)) begin
                    r_next.phase = PH_RUN; // RL5
                end
            end
            PH_RUN: begin
                if (r_reg.sleepEn) begin
                    r_next.phase = PH_SLEEP; // RL12
                end
            end
            PH_SLEEP: begin
                if (!r_reg.sleepEn) begin
                    r_next.phase = PH_WAKE; // RL20
                    r_next.cnt = '0;
                end
            end
            PH_WAKE: begin
                if (r_reg.sleepEn) begin
                    r_next.phase = PH_SLEEP;
                end else if (r_reg.cnt == CNT_W'(WAKE_CYCLES - 1)) begin
                    r_next.phase = PH_RUN; // RL14
                end
            end
            PH_PDOWN: begin
                if (r_reg.lvl.fullPowerDownPinN) begin
                    r_next.phase = PH_PUP;
                    r_next.cnt = '0;
                end
            end
            PH_PUP: begin
                if (r_reg.cnt == CNT_W'(PUP_CYCLES - 1)) begin
                    r_next.phase = PH_STARTUP; // RL17
                    r_next.cnt = '0;
                end
            end
            default: begin
                r_next.phase = PH_STRAP;
                r_next.cnt = '0;
            end
        endcase

        // power-down pin beats reset; neither applies before the straps are held
        if (r_reg.strapDone) begin
            if (!r_reg.lvl.fullPowerDownPinN) begin
                r_next = apcrc_defaults(r_next); // RL16 RL17
                r_next.phase = PH_PDOWN;
                r_next.cnt = '0;
            end else if ((!r_reg.lvl.resetPinN || r_reg.softRst)
                && !(r_reg.phase inside {PH_PDOWN, PH_PUP})) begin
                r_next = apcrc_defaults(r_next); // RL18 RL19
                r_next.phase = PH_STARTUP;
                r_next.cnt = '0;
            end
        end

        // outputs follow the next phase so they line up with it
        analogOn = r_next.phase inside {PH_STARTUP, PH_RUN, PH_WAKE}; // RL13
        on = analogOn ? ~(r_next.chPd & {NUM_CH{r_next.serialMode}}) : '0; // RL10
        r_next.power.channelOn = on;
        r_next.power.channelInputHiZ = ~on; // RL11 RL15
        r_next.power.referenceInputHiZ = ~analogOn; // RL15
        r_next.power.analogOn = analogOn;
        r_next.power.regulatorOn = r_next.phase != PH_PDOWN; // RL13 RL16
        r_next.clock.useExternalClock =
            r_next.phase inside {PH_RUN, PH_SLEEP, PH_WAKE}; // RL5
        r_next.clock.crystalClockOutEnable = r_next.crystalStrap & analogOn
            & (r_next.serialMode ? r_next.xclkEn : 1'b1); // RL7 RL8
        r_next.clock.lowPowerMode =
            r_next.serialMode ? r_next.lowPwr : r_next.lvl.lowPowerPin; // RL9
        r_next.refCorr.enable = r_next.serialMode & r_next.corrEn & analogOn; // RL2 RL4
        r_next.refCorr.currentQuarters = apcrc_quarters(on); // RL3
        r_next.ready = r_next.phase == PH_RUN;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge clk) begin
        if (reset) begin
            r_reg <= '0;
            r_reg.s1 <= PINS_IDLE;
            r_reg.s2 <= PINS_IDLE;
            r_reg.s3 <= PINS_IDLE;
            r_reg.lvl <= PINS_IDLE;
            r_reg.phase <= PH_STRAP;
            r_reg.power <= POWER_OFF;
        end else begin
            r_reg <= r_next;
        end
    end

    assign wbAck = r_reg.ack;
    assign wbDatOut = r_reg.rdat;
    assign powerOut = r_reg.power;
    assign clockOut = r_reg.clock;
    assign refCorrOut = r_reg.refCorr;
    assign deviceReady = r_reg.ready;

    // modulators only run on the external clock while analog is up
    apcrc_mod_clock #(
        .HALF_HP(MOD_HALF_HP)
    ) apcrc_mod_clock_i (
        .clk(clk),
        .reset(reset),
        .run(r_reg.power.analogOn & r_reg.clock.useExternalClock),
        .halfRate(r_reg.clock.lowPowerMode), // RL9
        .modClk(modulatorClock)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    AST_STRAP_HELD: assert property ( // RL1 RL6
        r_reg.strapDone |=> $stable(r_reg.serialMode) && $stable(r_reg.crystalStrap))
        else $error("strap choice changed after power-up");

    AST_CORR_ACTIVE: assert property ( // RL2 RL3
        r_reg.serialMode && r_reg.corrEn && r_reg.phase == PH_RUN
        |-> refCorrOut.enable
            && refCorrOut.currentQuarters == 3'(NUM_CH - $countones(r_reg.chPd)))
        else $error("reference correction wrong in serial mode");

    AST_PIN_NO_CORR: assert property ( // RL4
        r_reg.strapDone && !r_reg.serialMode |-> !refCorrOut.enable)
        else $error("reference correction on in pin mode");

    AST_HANDOVER: assert property ( // RL5
        $rose(clockOut.useExternalClock)
        |-> $past(r_reg.phase) == PH_STARTUP || $past(r_reg.phase) == PH_RUN)
        else $error("external clock taken before start-up ended");

    AST_XCLK_PIN: assert property ( // RL7
        r_reg.strapDone && !r_reg.serialMode && r_reg.phase == PH_RUN
        |-> clockOut.crystalClockOutEnable == r_reg.crystalStrap)
        else $error("crystal clock output wrong in pin mode");

    AST_XCLK_SPI: assert property ( // RL8
        r_reg.serialMode && !r_reg.xclkEn |-> !clockOut.crystalClockOutEnable)
        else $error("crystal clock output on without enable");

    AST_CH_HIZ: assert property ( // RL10 RL11
        r_reg.serialMode && r_reg.phase == PH_RUN
        |-> powerOut.channelInputHiZ == r_reg.chPd && powerOut.channelOn == ~r_reg.chPd)
        else $error("channel power-down not reflected");

    AST_SLEEP_ENTRY: assert property ( // RL12
        r_reg.phase == PH_RUN && r_reg.sleepEn && r_reg.lvl.fullPowerDownPinN
        && r_reg.lvl.resetPinN && !r_reg.softRst |=> r_reg.phase == PH_SLEEP)
        else $error("sleep not entered");

    AST_SLEEP_OFF: assert property ( // RL13 RL15
        r_reg.phase == PH_SLEEP |-> powerOut.referenceInputHiZ
        && &powerOut.channelInputHiZ && !powerOut.analogOn && powerOut.regulatorOn
        && !deviceReady)
        else $error("sleep state outputs wrong");

    AST_WAKE_BOUND: assert property ( // RL14
        r_reg.phase == PH_WAKE |-> r_reg.cnt < CNT_W'(WAKE_CYCLES))
        else $error("wake-up overran its time");

    AST_PDOWN: assert property ( // RL16 RL17
        r_reg.strapDone && !r_reg.lvl.fullPowerDownPinN
        |=> r_reg.phase == PH_PDOWN && !powerOut.regulatorOn && r_reg.chPd == CHPD_RST
            && !r_reg.sleepEn)
        else $error("power-down pin not obeyed");

    AST_SOFT_RESET: assert property ( // RL18 RL19
        r_reg.softRst && r_reg.lvl.fullPowerDownPinN
        |=> !r_reg.softRst && r_reg.phase == PH_STARTUP && !r_reg.corrEn
            && !r_reg.xclkEn && r_reg.chPd == CHPD_RST)
        else $error("software reset did not restore defaults");

    AST_WAKE_START: assert property ( // RL20
        r_reg.phase == PH_SLEEP && !r_reg.sleepEn && r_reg.lvl.fullPowerDownPinN
        && r_reg.lvl.resetPinN && !r_reg.softRst |=> r_reg.phase == PH_WAKE)
        else $error("clearing sleep did not start wake-up");

endmodule

// ### verification/apcrc_host_model.sv
module apcrc_host_model
    import apcrc_pkg::*;
(
    // clock
    input wire logic clk,
    // register bus
    output apcrc_wb_req_t wbReq,
    input wire logic wbAck,
    input wire logic [31:0] wbDatOut
);
    timeunit 1ns;
    timeprecision 1ps;

    initial wbReq = '0;

    ////////////////////////////////////////////////////////////////////////////////
    // one classic cycle; ack and data are read on the falling edge before the
    // rising edge that takes them, so no race with the slave's own update
    task automatic xfer(input logic [3:0] adr, input logic we, input logic [31:0] dat,
                        output logic [31:0] rdat, output logic ok);
        logic a;
        a = 1'b0;
        ok = 1'b0;
        rdat = '0;
        @(posedge clk);
        wbReq <= {adr, dat, 4'hF, we, 2'h3};
        for (int i = 0; i < 16 && !ok; i++) begin
            @(negedge clk);
            a = wbAck;
            rdat = wbDatOut;
            @(posedge clk);
            ok = (a === 1'b1);
        end
        wbReq <= '0;
    endtask
endmodule

// ### verification/apcrc_tb_top.sv
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin n_mismatch++; \
    $display("[ERR] %s expected %0h seen %0h", nm, ex, got); end end

module apcrc_tb_top import apcrc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    // shortened wake and power-up counts keep the run brief
    localparam int WK = 20;
    localparam int PU = 30;
    localparam logic [3:0] chPd[4] = '{4'h1, 4'h3, 4'h7, 4'hF};
    logic clk = 1'b0;
    logic reset = 1'b1;
    apcrc_pins_t pins = 5'h1E;
    apcrc_wb_req_t wbReq;
    logic wbAck;
    logic [31:0] wbDatOut;
    apcrc_power_t powerOut;
    apcrc_clock_t clockOut;
    apcrc_refcorr_t refCorrOut;
    logic deviceReady;
    logic modulatorClock;
    logic [31:0] rd;
    int cnt;
    int n_mismatch = 0;
    int comparisons = 0;

    apcrc_top #(.WAKE_CYCLES(WK), .PUP_CYCLES(PU), .CNT_W(21)) apcrc_top_i (
        .clk(clk), .reset(reset), .wbReq(wbReq), .wbAck(wbAck), .wbDatOut(wbDatOut),
        .pinsIn(pins), .powerOut(powerOut), .clockOut(clockOut), .refCorrOut(refCorrOut),
        .deviceReady(deviceReady), .modulatorClock(modulatorClock));

    apcrc_host_model apcrc_host_model_i (
        .clk(clk), .wbReq(wbReq), .wbAck(wbAck), .wbDatOut(wbDatOut));

    initial begin
        forever #4 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic fail_timeout(input string what);
        $display("[ERR] %s expected done seen timeout", what);
        n_mismatch++;
        final_report();
    endtask

    task automatic wr(input logic [3:0] adr, input logic [31:0] dat);
        logic [31:0] d;
        logic ok;
        apcrc_host_model_i.xfer(adr, 1'b1, dat, d, ok);
        if (!ok) fail_timeout("wb write");
    endtask

    task automatic rd32(input logic [3:0] adr, output logic [31:0] d);
        logic ok;
        apcrc_host_model_i.xfer(adr, 1'b0, 32'h0, d, ok);
        if (!ok) fail_timeout("wb read");
    endtask

    task automatic wait_ready(input int bound, output int c);
        c = 0;
        do begin
            @(negedge clk);
            c++;
        end while (deviceReady !== 1'b1 && c < bound);
        if (deviceReady !== 1'b1) fail_timeout("deviceReady");
    endtask

    // cycles between two toggles of the modulator clock
    task automatic half_period(output int h);
        logic m;
        h = 0;
        repeat (4) @(negedge clk);
        m = modulatorClock;
        for (int i = 0; i < 8 && modulatorClock === m; i++) @(negedge clk);
        m = modulatorClock;
        while (modulatorClock === m && h < 8) begin
            @(negedge clk);
            h++;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic boot_check();
        repeat (12) @(negedge clk);
        `CHK("extClkEarly", 1'b0, clockOut.useExternalClock)
        wait_ready(400, cnt);
        `CHK("extClkLate", 1'b1, clockOut.useExternalClock)
    endtask

    // straps only count at power-on, so each pin mode needs a fresh reset
    task automatic power_on(input logic sel, input logic xtal);
        @(posedge clk);
        pins <= {sel, xtal, 3'h6};
        repeat (6) @(posedge clk);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        boot_check();
    endtask

    task automatic t_lowpower();
        int h;
        half_period(h);
        `CHK("halfHp", MOD_HALF_HP, h)
        wr(ADDR_CTRL, 32'h4);
        half_period(h);
        `CHK("lowPwr", 1'b1, clockOut.lowPowerMode)
        `CHK("halfLp", 2 * MOD_HALF_HP, h)
    endtask

    task automatic t_serial();
        rd32(ADDR_STATUS, rd);
        `CHK("status", 32'h17, rd)
        `CHK("xclkRst", 1'b0, clockOut.crystalClockOutEnable)
        wr(ADDR_CTRL, 32'h3);
        rd32(ADDR_CTRL, rd);
        `CHK("ctrl", 32'h3, rd)
        `CHK("xclkOn", 1'b1, clockOut.crystalClockOutEnable)
        `CHK("corrOn", 1'b1, refCorrOut.enable)
        foreach (chPd[i]) begin
            wr(ADDR_CHPD, {28'h0, chPd[i]});
            repeat (2) @(negedge clk);
            `CHK("chOn", ~chPd[i], powerOut.channelOn)
            `CHK("chHiZ", chPd[i], powerOut.channelInputHiZ)
            `CHK("quarters", 3'(4 - $countones(chPd[i])), refCorrOut.currentQuarters)
        end
        rd32(4'hC, rd);
        `CHK("unmapped", 32'h0, rd)
    endtask

    task automatic t_sleep();
        wr(ADDR_CHPD, 32'h5);
        wr(ADDR_CTRL, 32'h8);
        repeat (2) @(negedge clk);
        `CHK("sleepPower", 11'h07D, powerOut)
        `CHK("sleepReady", 1'b0, deviceReady)
        rd32(ADDR_CHPD, rd);
        `CHK("chpdKept", 32'h5, rd)
        wr(ADDR_CTRL, 32'h0);
        wait_ready(WK + 10, cnt);
        `CHK("wakeTime", 1'b1, cnt <= WK + 3)
    endtask

    task automatic t_softreset();
        wr(ADDR_CTRL, 32'h13);
        repeat (2) @(negedge clk);
        `CHK("srstBusy", 1'b0, deviceReady)
        wait_ready(400, cnt);
        rd32(ADDR_CTRL, rd);
        `CHK("ctrlDef", 32'h0, rd)
        rd32(ADDR_CHPD, rd);
        `CHK("chpdDef", 32'h0, rd)
    endtask

    task automatic t_pinreset();
        wr(ADDR_CTRL, 32'h2);
        @(posedge clk);
        pins.resetPinN <= 1'b0;
        repeat (5) @(posedge clk);
        pins.resetPinN <= 1'b1;
        repeat (6) @(negedge clk);
        `CHK("pinRstBusy", 1'b0, deviceReady)
        wait_ready(400, cnt);
        rd32(ADDR_CTRL, rd);
        `CHK("ctrlDefPin", 32'h0, rd)
    endtask

    task automatic t_pdown();
        wr(ADDR_CTRL, 32'h2);
        @(posedge clk);
        pins.fullPowerDownPinN <= 1'b0;
        repeat (46) @(negedge clk);
        `CHK("pdPower", 11'h07C, powerOut)
        `CHK("pdReady", 1'b0, deviceReady)
        @(posedge clk);
        pins.fullPowerDownPinN <= 1'b1;
        wait_ready(PU + 400, cnt);
        `CHK("pupTime", 1'b1, cnt >= PU)
        rd32(ADDR_CTRL, rd);
        `CHK("ctrlDefPd", 32'h0, rd)
    endtask

    task automatic t_pinmode();
        power_on(1'b0, 1'b1);
        `CHK("pinXclk", 1'b1, clockOut.crystalClockOutEnable)
        wr(ADDR_CTRL, 32'h1);
        repeat (2) @(negedge clk);
        `CHK("pinCorr", 1'b0, refCorrOut.enable)
        @(posedge clk);
        pins.lowPowerPin <= 1'b1;
        repeat (6) @(negedge clk);
        `CHK("pinLowPwr", 1'b1, clockOut.lowPowerMode)
        power_on(1'b0, 1'b0);
        `CHK("cmosXclk", 1'b0, clockOut.crystalClockOutEnable)
        rd32(ADDR_STATUS, rd);
        `CHK("statusPin", 32'h14, rd)
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        boot_check();
        t_lowpower();
        t_serial();
        t_sleep();
        t_softreset();
        t_pinreset();
        t_pdown();
        t_pinmode();
        final_report();
    end
endmodule
